// file: src/bldc_pkg.sv
// Shared constants, types and decode helpers of the motor driver logic.
// Assumes a single system clock domain and an AHB-Lite register slave.
package bldc_pkg;
	localparam logic [31:0] REG_CTRL = 32'h0000_0000;
	localparam logic [31:0] REG_STATUS = 32'h0000_0004;
	localparam logic [31:0] REG_REVS = 32'h0000_0008;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	localparam logic [31:0] CTRL_MASK = 32'h0000_0007;
	localparam int CTRL_RUN = 0;
	localparam int CTRL_POLE_OVR = 1;
	localparam int CTRL_POLE_SEL = 2;
	localparam int ST_HALL = 0;
	localparam int ST_UV = 3;
	localparam int ST_OT = 4;
	localparam int ST_BAD = 5;
	localparam int ST_SPEED = 6;
	localparam int ST_MODE = 7;
	localparam int ST_OE = 9;
	localparam int ST_LEVEL = 12;
	localparam int REVS_W = 16;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [2:0] HALL_LOW = 3'h0;
	localparam logic [2:0] HALL_HIGH = 3'h7;
	localparam logic [3:0] POLES_LOW = 4'h4;
	localparam logic [3:0] POLES_HIGH = 4'h8;
	localparam int PIN_HALL = 0;
	localparam int PIN_EN = 3;
	localparam int PIN_BRK_N = 4;
	localparam int PIN_POLE = 5;
	localparam int PIN_UV = 6;
	localparam int PIN_OT = 7;
	localparam int PIN_ERR = 8;
	localparam int PIN_W = 9;
	// Brake input idles released so reset never pulses the sinks
	localparam logic [8:0] PIN_RESET = 9'h010;

	typedef enum logic [1:0] {
		MODE_OFF = 2'b00,
		MODE_BRAKE = 2'b01,
		MODE_FAULT = 2'b10,
		MODE_RUN = 2'b11
	} drive_mode_t;

	// Bit 2 is phase A, bit 1 phase B, bit 0 phase C
	typedef struct packed {
		logic [2:0] oe;
		logic [2:0] level;
	} phase_drive_t;

	function automatic logic hall_invalid(input logic [2:0] code);
		return (code == HALL_LOW) || (code == HALL_HIGH);
	endfunction : hall_invalid

	function automatic phase_drive_t commutate(input logic [2:0] code);
		phase_drive_t d;
		d.oe = 3'h0;
		d.level = 3'h0;
		case (code)
			3'h5: begin d.oe = 3'h6; d.level = 3'h4; end
			3'h4: begin d.oe = 3'h5; d.level = 3'h4; end
			3'h6: begin d.oe = 3'h3; d.level = 3'h2; end
			3'h2: begin d.oe = 3'h6; d.level = 3'h2; end
			3'h3: begin d.oe = 3'h5; d.level = 3'h1; end
			3'h1: begin d.oe = 3'h3; d.level = 3'h1; end
			default: begin d.oe = 3'h0; d.level = 3'h0; end
		endcase
		return d;
	endfunction : commutate
endpackage : bldc_pkg

// file: src/pin_sync.sv
// Two-stage synchroniser for a vector of asynchronous pin levels.
// Assumes levels only; no pulse shorter than one clock is preserved.
`timescale 1ns/100ps
module pin_sync #(
	parameter int WIDTH = 9,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta;

	if (WIDTH < 1) begin : g_width_check
		$error("pin_sync width must be positive");
	end

	// First stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta <= RESET_VAL;
			sync_out <= RESET_VAL;
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end
endmodule : pin_sync

// file: src/speed_divider.sv
// Edge divider for the speed pulse: toggles after a set number of edges.
// Assumes edge_in is a one-cycle pulse on the system clock.
`timescale 1ns/100ps
module speed_divider #(
	parameter int MAX_DIV = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic edge_in,
	input wire logic [3:0] divide_by,
	output logic speed,
	output logic toggled
);
	logic [3:0] count;
	logic [3:0] next_count;
	logic next_speed;
	logic next_toggled;

	if (MAX_DIV < 2 || MAX_DIV > 15) begin : g_div_check
		$error("speed_divider MAX_DIV out of range");
	end

	always_comb begin
		next_count = count;
		next_speed = speed;
		next_toggled = 1'b0;
		if (clear) begin
			next_count = 4'h0;
			next_speed = 1'b0;
		end else if (edge_in) begin
			if (count + 4'h1 >= divide_by) begin
				next_count = 4'h0;
				next_speed = !speed;
				next_toggled = 1'b1;
			end else begin
				next_count = count + 4'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count <= 4'h0;
			speed <= 1'b0;
			toggled <= 1'b0;
		end else begin
			count <= next_count;
			speed <= next_speed;
			toggled <= next_toggled;
		end
	end
endmodule : speed_divider

// file: src/bldc_commutation_fault_speed_pulse.sv
// Commutation, brake, fault flag and speed pulse of a three-phase driver.
// Assumes asynchronous pins, one 100 MHz clock and an AHB-Lite master.
`timescale 1ns/100ps
module bldc_commutation_fault_speed_pulse (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic HALL_SENSE_A,
	input wire logic HALL_SENSE_B,
	input wire logic HALL_SENSE_C,
	input wire logic CHIP_ENABLE,
	input wire logic BRAKE_N,
	input wire logic POLE_SELECT,
	input wire logic SUPPLY_LOW,
	input wire logic OVER_TEMP,
	input wire logic ERROR_DRIVE,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	output logic PHASE_A_OUT,
	output logic PHASE_A_OE,
	output logic PHASE_B_OUT,
	output logic PHASE_B_OE,
	output logic PHASE_C_OUT,
	output logic PHASE_C_OE,
	output logic [2:0] SINK_GATE,
	output logic FAULT_N,
	output logic SPEED_PULSE
);
	import bldc_pkg::*;

	logic [PIN_W-1:0] pins_raw;
	logic [PIN_W-1:0] pins;
	logic [2:0] hall;
	logic en;
	logic brk_n;
	logic uv;
	logic ot;
	logic err;
	logic bad;
	logic run_en;
	logic pole_eff;
	logic [3:0] divide_by;
	logic hall_a_prev;
	logic a_edge;
	logic toggled;

	drive_mode_t mode;
	drive_mode_t next_mode;
	phase_drive_t drive;
	phase_drive_t next_drive;
	logic [2:0] next_sink;
	logic next_fault_n;
	logic next_hall_a_prev;

	logic [31:0] ctrl;
	logic [31:0] next_ctrl;
	logic [REVS_W-1:0] revs;
	logic [REVS_W-1:0] next_revs;
	logic wr_pend;
	logic next_wr_pend;
	logic [31:0] wr_addr;
	logic [31:0] next_wr_addr;
	logic [31:0] next_rdata;
	logic [31:0] status;
	logic [31:0] ctrl_view;
	logic addr_ok;

	assign pins_raw = {ERROR_DRIVE, OVER_TEMP, SUPPLY_LOW, POLE_SELECT, BRAKE_N,
		CHIP_ENABLE, HALL_SENSE_A, HALL_SENSE_B, HALL_SENSE_C};

	// Control pins share the Hall synchroniser; all are off-domain levels
	pin_sync #(
		.WIDTH(PIN_W),
		.RESET_VAL(PIN_RESET)
	) u_sync (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.async_in(pins_raw),
		.sync_out(pins)
	);

	assign hall = pins[PIN_HALL +: 3];
	assign en = pins[PIN_EN];
	assign brk_n = pins[PIN_BRK_N];
	assign uv = pins[PIN_UV];
	assign ot = pins[PIN_OT];
	assign err = pins[PIN_ERR];
	assign bad = hall_invalid(hall);
	assign run_en = en && ctrl[CTRL_RUN];
	assign pole_eff = ctrl[CTRL_POLE_OVR] ? ctrl[CTRL_POLE_SEL] : pins[PIN_POLE];
	assign divide_by = pole_eff ? POLES_HIGH : POLES_LOW;
	assign a_edge = (hall[2] ^ hall_a_prev) && mode != MODE_OFF;

	// Both edges of input A count, so one pole pass is one edge
	speed_divider #(
		.MAX_DIV(8)
	) u_div (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.clear(!run_en),
		.edge_in(a_edge),
		.divide_by(divide_by),
		.speed(SPEED_PULSE),
		.toggled(toggled)
	);

	// Drive state
	always_comb begin
		next_hall_a_prev = hall[2];
		if (!brk_n) begin
			next_mode = MODE_BRAKE;
		end else if (!run_en) begin
			next_mode = MODE_OFF;
		end else if (ot || bad) begin
			next_mode = MODE_FAULT;
		end else begin
			next_mode = MODE_RUN;
		end
		case (next_mode)
			MODE_BRAKE: begin
				next_drive.oe = 3'h7;
				next_drive.level = 3'h0;
				next_sink = 3'h7;
			end
			MODE_RUN: begin
				next_drive = commutate(hall);
				next_sink = err ? (next_drive.oe & ~next_drive.level) : 3'h0;
			end
			default: begin
				next_drive.oe = 3'h0;
				next_drive.level = 3'h0;
				next_sink = 3'h0;
			end
		endcase
		next_fault_n = !(uv || ot || bad);
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			mode <= MODE_OFF;
			drive <= '0;
			SINK_GATE <= 3'h0;
			FAULT_N <= 1'b1;
			hall_a_prev <= 1'b0;
		end else begin
			mode <= next_mode;
			drive <= next_drive;
			SINK_GATE <= next_sink;
			FAULT_N <= next_fault_n;
			hall_a_prev <= next_hall_a_prev;
		end
	end

	assign PHASE_A_OUT = drive.level[2];
	assign PHASE_A_OE = drive.oe[2];
	assign PHASE_B_OUT = drive.level[1];
	assign PHASE_B_OE = drive.oe[1];
	assign PHASE_C_OUT = drive.level[0];
	assign PHASE_C_OE = drive.oe[0];

	// Register slave, zero wait states
	assign addr_ok = HSEL && HREADY && (HTRANS & HTRANS_NONSEQ) == HTRANS_NONSEQ
		&& HSIZE == HSIZE_WORD;

	always_comb begin
		status = 32'h0000_0000;
		status[ST_HALL +: 3] = hall;
		status[ST_UV] = uv;
		status[ST_OT] = ot;
		status[ST_BAD] = bad;
		status[ST_SPEED] = SPEED_PULSE;
		status[ST_MODE +: 2] = mode;
		status[ST_OE +: 3] = drive.oe;
		status[ST_LEVEL +: 3] = drive.level;
		// A read right behind a write must see the new value
		ctrl_view = (wr_pend && wr_addr == REG_CTRL) ? (HWDATA & CTRL_MASK) : ctrl;
		next_wr_pend = addr_ok && HWRITE;
		next_wr_addr = HADDR;
		next_rdata = 32'h0000_0000;
		if (addr_ok && !HWRITE) begin
			case (HADDR)
				REG_CTRL: next_rdata = ctrl_view;
				REG_STATUS: next_rdata = status;
				REG_REVS: next_rdata = {{(32 - REVS_W){1'b0}}, revs};
				default: next_rdata = 32'h0000_0000;
			endcase
		end
		next_ctrl = ctrl_view;
		next_revs = toggled ? revs + 16'h0001 : revs;
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			ctrl <= CTRL_RESET;
			revs <= '0;
			wr_pend <= 1'b0;
			wr_addr <= 32'h0000_0000;
			HRDATA <= 32'h0000_0000;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			revs <= next_revs;
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			HRDATA <= next_rdata;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end
	end

	// Checks
	logic [PIN_W-1:0] raw_d1;
	logic [PIN_W-1:0] raw_d2;
	logic [3:0] edge_tally;
	logic speed_prev;

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			raw_d1 <= PIN_RESET;
			raw_d2 <= PIN_RESET;
			edge_tally <= 4'h0;
			speed_prev <= 1'b0;
		end else begin
			raw_d1 <= pins_raw;
			raw_d2 <= raw_d1;
			speed_prev <= SPEED_PULSE;
			if (!run_en) begin
				edge_tally <= 4'h0;
			end else if (SPEED_PULSE != speed_prev) begin
				edge_tally <= {3'h0, a_edge};
			end else begin
				edge_tally <= edge_tally + {3'h0, a_edge};
			end
		end
	end

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);

	sequence s_run_ok;
		brk_n && run_en && !ot && !bad;
	endsequence

	sequence s_stable_speed;
		($stable(SPEED_PULSE) || !$past(run_en))[*3];
	endsequence

	property p_enable_off;
		!en && brk_n |=> drive.oe == 3'h0 && SINK_GATE == 3'h0;
	endproperty
	a_enable_off: assert property (p_enable_off) else $error("phases driven while disabled");

	property p_brake;
		!brk_n |=> drive.oe == 3'h7 && drive.level == 3'h0 && SINK_GATE == 3'h7;
	endproperty
	a_brake: assert property (p_brake) else $error("brake did not close all sinks");

	property p_fault_flag;
		(uv || ot || bad) != 1'b0 |=> !FAULT_N;
	endproperty
	a_fault_flag: assert property (p_fault_flag) else $error("fault flag missed a condition");

	property p_bad_hall;
		bad && brk_n |=> drive.oe == 3'h0 && !FAULT_N;
	endproperty
	a_bad_hall: assert property (p_bad_hall) else $error("invalid hall code not handled");

	property p_over_temp;
		ot && brk_n |=> drive.oe == 3'h0 && SINK_GATE == 3'h0 && !FAULT_N;
	endproperty
	a_over_temp: assert property (p_over_temp) else $error("overtemp left drivers on");

	property p_undervolt;
		!uv && !ot && !bad |=> FAULT_N;
	endproperty
	a_undervolt: assert property (p_undervolt) else $error("fault flag low without cause");

	property p_speed_src;
		$changed(SPEED_PULSE) && $past(run_en) |-> $past(a_edge);
	endproperty
	a_speed_src: assert property (p_speed_src) else $error("speed toggled without edge");

	property p_pole_div;
		$changed(SPEED_PULSE) && $past(run_en) |-> $past(edge_tally) + 4'h1 == $past(divide_by);
	endproperty
	a_pole_div: assert property (p_pole_div) else $error("speed divide ratio wrong");

	property p_once;
		$changed(SPEED_PULSE) && run_en |=> s_stable_speed;
	endproperty
	a_once: assert property (p_once) else $error("speed toggled too soon");

	property p_sink_route;
		(SINK_GATE & ~(drive.oe & ~drive.level)) == 3'h0;
	endproperty
	a_sink_route: assert property (p_sink_route) else $error("error drive on wrong sink");

	property p_step_map;
		s_run_ok ##0 (hall == 3'h5) |=> PHASE_A_OE && PHASE_A_OUT && PHASE_B_OE
			&& !PHASE_B_OUT && !PHASE_C_OE;
	endproperty
	a_step_map: assert property (p_step_map) else $error("six-step map wrong");

	property p_brake_first;
		!brk_n && !en && bad |=> drive.oe == 3'h7 && mode == MODE_BRAKE;
	endproperty
	a_brake_first: assert property (p_brake_first) else $error("brake lost priority");

	property p_sync_depth;
		pins == raw_d2;
	endproperty
	a_sync_depth: assert property (p_sync_depth) else $error("pin sync depth wrong");

	property p_clear;
		!run_en |=> !SPEED_PULSE && edge_tally == 4'h0;
	endproperty
	a_clear: assert property (p_clear) else $error("divider not cleared");
endmodule : bldc_commutation_fault_speed_pulse

// file: bench/hall_sensor_model.sv
// Hall sensor model: steps the six-step code sequence on request.
// Assumes requests from the bench on the rising clock edge.
`timescale 1ns/100ps
module hall_sensor_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [7:0] n_steps,
	input wire logic [7:0] period,
	input wire logic ovr_en,
	input wire logic [2:0] ovr_code,
	output logic hall_sense_a,
	output logic hall_sense_b,
	output logic hall_sense_c,
	output logic busy
);
	// Sensors 120 degrees apart give one bit change per step
	localparam logic [2:0] SEQ [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
	logic [2:0] pos;
	logic [7:0] left;
	logic [7:0] wait_cnt;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pos <= 3'h0;
			left <= 8'h00;
			wait_cnt <= 8'h00;
		end else if (load) begin
			left <= n_steps;
			wait_cnt <= period;
		end else if (left != 8'h00) begin
			if (wait_cnt != 8'h00) begin
				wait_cnt <= wait_cnt - 8'h01;
			end else begin
				pos <= (pos == 3'h5) ? 3'h0 : pos + 3'h1;
				left <= left - 8'h01;
				wait_cnt <= period;
			end
		end
	end

	// Override only for scenarios that need a fixed or broken code
	assign {hall_sense_a, hall_sense_b, hall_sense_c} = ovr_en ? ovr_code : SEQ[pos];
	assign busy = (left != 8'h00);
endmodule : hall_sensor_model

// file: bench/tb_top.sv
// Self-checking bench of the motor driver logic.
// Assumes the Hall sensor model and a bus master acting from this module.
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
	import bldc_pkg::*;
	localparam logic [5:0] RUN_MAP [6] = '{6'h34, 6'h2c, 6'h1a, 6'h32, 6'h29, 6'h19};
	localparam logic [2:0] RUN_CODE [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
	logic CLK_SYS = 1'b0;
	logic RST_N = 1'b0;
	logic CHIP_ENABLE = 1'b1;
	logic BRAKE_N = 1'b1;
	logic POLE_SELECT = 1'b0;
	logic SUPPLY_LOW = 1'b0;
	logic OVER_TEMP = 1'b0;
	logic ERROR_DRIVE = 1'b0;
	logic HSEL = 1'b0;
	logic [31:0] HADDR = 32'h0000_0000;
	logic [1:0] HTRANS = 2'h0;
	logic HWRITE = 1'b0;
	logic [2:0] HSIZE = 3'h0;
	logic [31:0] HWDATA = 32'h0000_0000;
	logic load = 1'b0;
	logic [7:0] n_steps = 8'h00;
	logic [7:0] period = 8'h00;
	logic ovr_en = 1'b1;
	logic [2:0] ovr_code = 3'h5;
	logic hall_sense_a, hall_sense_b, hall_sense_c, busy, spd_last;
	logic [31:0] HRDATA;
	logic HREADYOUT, HRESP, FAULT_N, SPEED_PULSE;
	logic PHASE_A_OUT, PHASE_A_OE, PHASE_B_OUT, PHASE_B_OE, PHASE_C_OUT, PHASE_C_OE;
	logic [2:0] SINK_GATE, oe, lvl;
	int n_mismatch = 0;
	int samples_checked = 0;
	int n_tog = 0;
	int cycles = 0;

	assign oe = {PHASE_A_OE, PHASE_B_OE, PHASE_C_OE};
	assign lvl = {PHASE_A_OUT, PHASE_B_OUT, PHASE_C_OUT};
	always #5 CLK_SYS = ~CLK_SYS;

	hall_sensor_model hall_sensor_model_inst (.clk(CLK_SYS), .rst_n(RST_N), .load(load),
		.n_steps(n_steps), .period(period), .ovr_en(ovr_en), .ovr_code(ovr_code),
		.hall_sense_a(hall_sense_a), .hall_sense_b(hall_sense_b),
		.hall_sense_c(hall_sense_c), .busy(busy));

	bldc_commutation_fault_speed_pulse bldc_commutation_fault_speed_pulse_inst (.CLK_SYS(CLK_SYS),
		.RST_N(RST_N), .HALL_SENSE_A(hall_sense_a), .HALL_SENSE_B(hall_sense_b),
		.HALL_SENSE_C(hall_sense_c), .CHIP_ENABLE(CHIP_ENABLE), .BRAKE_N(BRAKE_N),
		.POLE_SELECT(POLE_SELECT), .SUPPLY_LOW(SUPPLY_LOW), .OVER_TEMP(OVER_TEMP),
		.ERROR_DRIVE(ERROR_DRIVE), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
		.HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
		.HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
		.PHASE_A_OUT(PHASE_A_OUT), .PHASE_A_OE(PHASE_A_OE), .PHASE_B_OUT(PHASE_B_OUT),
		.PHASE_B_OE(PHASE_B_OE), .PHASE_C_OUT(PHASE_C_OUT), .PHASE_C_OE(PHASE_C_OE),
		.SINK_GATE(SINK_GATE), .FAULT_N(FAULT_N), .SPEED_PULSE(SPEED_PULSE));

	// Sampled away from the edge so register updates never race the count
	always @(negedge CLK_SYS) begin
		if (SPEED_PULSE !== spd_last) n_tog++;
		spd_last = SPEED_PULSE;
	end

	always @(posedge CLK_SYS) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("Checked %0d, mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : print_verdict

	// Pins pass two sync stages, so four edges always cover the delay
	task automatic settle();
		repeat (4) @(posedge CLK_SYS);
		#1;
	endtask : settle

	task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge CLK_SYS);
		HSEL <= 1'b1;
		HADDR <= addr;
		HTRANS <= HTRANS_NONSEQ;
		HWRITE <= wr;
		HSIZE <= HSIZE_WORD;
		do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= wd;
		do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
		rd = HRDATA;
	endtask : bus

	task automatic spin(input int n, input int per);
		@(posedge CLK_SYS);
		load <= 1'b1;
		n_steps <= 8'(n);
		period <= 8'(per);
		@(posedge CLK_SYS);
		load <= 1'b0;
		do @(posedge CLK_SYS); while (busy === 1'b1);
		settle();
	endtask : spin

	task automatic t_regs();
		logic [31:0] rd;
		bus(1'b0, REG_CTRL, 32'h0000_0000, rd);
		`CHK(rd, CTRL_RESET)
		`CHK({HREADYOUT, HRESP}, 2'h2)
		bus(1'b1, REG_CTRL, 32'h0000_0000, rd);
		settle();
		`CHK(oe, 3'h0)
		bus(1'b0, REG_STATUS, 32'h0000_0000, rd);
		`CHK(rd[ST_HALL +: 3], 3'h5)
		bus(1'b1, REG_CTRL, CTRL_RESET, rd);
		bus(1'b0, 32'h0000_0010, 32'h0000_0000, rd);
		`CHK(rd, 32'h0000_0000)
		settle();
		`CHK(oe, 3'h6)
	endtask : t_regs

	task automatic t_map();
		@(posedge CLK_SYS);
		ERROR_DRIVE <= 1'b1;
		ovr_code <= 3'h4;
		repeat (2) @(posedge CLK_SYS);
		#1;
		`CHK(oe, 3'h6)
		@(posedge CLK_SYS);
		#1;
		`CHK(oe, 3'h5)
		for (int i = 0; i < 6; i++) begin
			@(posedge CLK_SYS);
			ovr_code <= RUN_CODE[i];
			settle();
			`CHK({oe, lvl & oe}, RUN_MAP[i])
			`CHK(SINK_GATE, RUN_MAP[i][5:3] & ~RUN_MAP[i][2:0])
		end
		@(posedge CLK_SYS);
		ERROR_DRIVE <= 1'b0;
		settle();
		`CHK(SINK_GATE, 3'h0)
	endtask : t_map

	task automatic t_faults();
		for (int i = 0; i < 2; i++) begin
			@(posedge CLK_SYS);
			ovr_code <= i ? HALL_HIGH : HALL_LOW;
			settle();
			`CHK(FAULT_N, 1'b0)
			`CHK(oe, 3'h0)
		end
		@(posedge CLK_SYS);
		ovr_code <= 3'h5;
		OVER_TEMP <= 1'b1;
		settle();
		`CHK(FAULT_N, 1'b0)
		`CHK(oe, 3'h0)
		@(posedge CLK_SYS);
		OVER_TEMP <= 1'b0;
		SUPPLY_LOW <= 1'b1;
		settle();
		`CHK({FAULT_N, oe}, 4'h6)
		@(posedge CLK_SYS);
		SUPPLY_LOW <= 1'b0;
		settle();
		`CHK(FAULT_N, 1'b1)
	endtask : t_faults

	task automatic t_brake();
		@(posedge CLK_SYS);
		BRAKE_N <= 1'b0;
		CHIP_ENABLE <= 1'b0;
		ovr_code <= HALL_HIGH;
		settle();
		`CHK({oe, lvl, SINK_GATE}, 9'h1c7)
		`CHK(FAULT_N, 1'b0)
		@(posedge CLK_SYS);
		BRAKE_N <= 1'b1;
		ovr_code <= 3'h5;
		settle();
		`CHK(oe, 3'h0)
		@(posedge CLK_SYS);
		CHIP_ENABLE <= 1'b1;
		settle();
		`CHK(oe, 3'h6)
	endtask : t_brake

	task automatic t_speed_pulse();
		logic [31:0] rd;
		logic [31:0] r0;
		@(posedge CLK_SYS);
		CHIP_ENABLE <= 1'b0;
		ovr_en <= 1'b0;
		settle();
		`CHK(SPEED_PULSE, 1'b0)
		@(posedge CLK_SYS);
		CHIP_ENABLE <= 1'b1;
		settle();
		n_tog = 0;
		spin(12, 1);
		`CHK({n_tog == 1, SPEED_PULSE}, 2'h3)
		@(posedge CLK_SYS);
		POLE_SELECT <= 1'b1;
		spin(12, 6);
		`CHK(n_tog, 1)
		@(posedge CLK_SYS);
		CHIP_ENABLE <= 1'b0;
		settle();
		`CHK(SPEED_PULSE, 1'b0)
		@(posedge CLK_SYS);
		CHIP_ENABLE <= 1'b1;
		settle();
		n_tog = 0;
		spin(12, 2);
		`CHK(n_tog, 0)
		bus(1'b0, REG_REVS, 32'h0000_0000, r0);
		spin(12, 2);
		`CHK(n_tog, 1)
		bus(1'b0, REG_REVS, 32'h0000_0000, rd);
		`CHK(rd - r0, 32'h0000_0001)
		// Register override picks four poles against the pin
		n_tog = 0;
		bus(1'b1, REG_CTRL, 32'h0000_0003, rd);
		spin(12, 2);
		`CHK(n_tog, 1)
	endtask : t_speed_pulse

	initial begin
		repeat (2) @(posedge CLK_SYS);
		RST_N <= 1'b1;
		settle();
		t_regs();
		t_map();
		t_faults();
		t_brake();
		t_speed_pulse();
		print_verdict();
	end
endmodule : tb_top
